/* File: rtl/sample_step_input_select.sv */
/*
 holds the per-step analog input selectors of one sample sequencer and picks the
 selector of the step being run. assumes a single ahb-lite master and a sequencer
 on the same clock that names the step it runs (0 = first step).
*/
`timescale 1ns/1ns

module sample_step_input_select (
	// clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_b_in,
	// register bus
	input  wire step_sel_pkg::ahb_req_t  ahb_in,
	output      step_sel_pkg::ahb_rsp_t  ahb_out,
	// sequencer
	input  wire step_sel_pkg::step_req_t step_in,
	output      step_sel_pkg::step_sel_t step_sel_out
);
	import step_sel_pkg::*;

	logic [1:0]  rst_sync;
	logic        rst_b;
	logic [31:0] step_sel;
	logic        wr_pend;
	logic [11:0] wr_addr;
	logic        rd_hit;
	logic        addr_ok;
	logic [31:0] hrdata;

	function automatic logic [1:0] field_of(input logic [31:0] r, input logic [2:0] s);
		logic [4:0] lsb;
		lsb = {s[2:0], 2'b00};
		field_of = r[lsb +: 2];
	endfunction

	// reset release kept clean of the async edge
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_b = rst_sync[1];

	wire logic addr_phase = ahb_in.sel && ahb_in.hready &&
		(ahb_in.htrans == htrans_nonseq || ahb_in.htrans == htrans_seq);

	// data phase bookkeeping; registers answer with no wait state
	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			rd_hit  <= 1'b0;
		end else begin
			wr_pend <= addr_phase && ahb_in.hwrite;
			wr_addr <= ahb_in.haddr[11:0];
			rd_hit  <= addr_phase && !ahb_in.hwrite;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			step_sel <= step_sel_reset;
		end else if (wr_pend && wr_addr == step_sel_offset) begin
			step_sel <= ahb_in.hwdata & step_sel_rw_mask;
		end
	end

	// unmapped offsets read zero, writes dropped; response stays okay
	assign addr_ok = (ahb_in.haddr[11:0] == step_sel_offset);
	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !ahb_in.hwrite) begin
			hrdata <= addr_ok ? (step_sel & step_sel_rw_mask) : 32'h0000_0000;
		end
	end

	assign ahb_out.hrdata    = hrdata;
	assign ahb_out.hreadyout = 1'b1;
	assign ahb_out.hresp     = 1'b0;

	// named views of each step's field, read by the checks below
	logic [1:0] step1_input_sel;
	logic [1:0] step2_input_sel;
	logic [1:0] step3_input_sel;
	logic [1:0] step4_input_sel;
	logic [1:0] step5_input_sel;
	logic [1:0] step6_input_sel;
	logic [1:0] step7_input_sel;
	assign step1_input_sel = step_sel[1:0];
	assign step2_input_sel = step_sel[5:4];
	assign step3_input_sel = step_sel[9:8];
	assign step4_input_sel = step_sel[13:12];
	assign step5_input_sel = step_sel[17:16];
	assign step6_input_sel = step_sel[21:20];
	assign step7_input_sel = step_sel[25:24];

	// value passed as the pin number
	always_ff @(posedge clk_sys_in or negedge rst_b) begin
		if (!rst_b) begin
			step_sel_out <= '0;
		end else begin
			step_sel_out.valid     <= step_in.valid && (step_in.step < 3'(step_count));
			step_sel_out.input_sel <= (step_in.step < 3'(step_count)) ?
				field_of(step_sel, step_in.step) : 2'b00;
		end
	end

	// assertions
	step1_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h0 |=> step_sel_out.input_sel == $past(step1_input_sel))
		else $error("step1 selector wrong");
	step2_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h1 |=> step_sel_out.input_sel == $past(step2_input_sel))
		else $error("step2 selector wrong");
	step3_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h2 |=> step_sel_out.input_sel == $past(step3_input_sel))
		else $error("step3 selector wrong");
	step4_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h3 |=> step_sel_out.input_sel == $past(step4_input_sel))
		else $error("step4 selector wrong");
	step5_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h4 |=> step_sel_out.input_sel == $past(step5_input_sel))
		else $error("step5 selector wrong");
	step6_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h5 |=> step_sel_out.input_sel == $past(step6_input_sel))
		else $error("step6 selector wrong");
	step7_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h6 |=> step_sel_out.input_sel == $past(step7_input_sel))
		else $error("step7 selector wrong");
	reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		(step_sel & ~step_sel_rw_mask) == 32'h0000_0000 && (hrdata & ~step_sel_rw_mask) == 32'h0)
		else $error("reserved bits not zero");
	write_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		wr_pend && wr_addr == step_sel_offset |=>
		step_sel == ($past(ahb_in.hwdata) & step_sel_rw_mask))
		else $error("write not stored");
	pin_number_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step < 3'h7 && $stable(step_sel) |=>
		step_sel_out.valid && step_sel_out.input_sel == field_of(step_sel, $past(step_in.step)))
		else $error("pin number not passed");

	// reset state and bus side
	reset_state_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		$rose(rst_b) |-> step_sel == step_sel_reset && hrdata == 32'h0000_0000)
		else $error("reset state wrong");
	reset_out_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		$rose(rst_b) |-> !step_sel_out.valid && step_sel_out.input_sel == 2'b00)
		else $error("step output not cleared by reset");
	read_data_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		rd_hit |-> hrdata == ($past(addr_ok) ? $past(step_sel & step_sel_rw_mask) : 32'h0))
		else $error("read data wrong");
	read_stands_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		!(addr_phase && !ahb_in.hwrite) |=> $stable(hrdata))
		else $error("read data moved");
	unmapped_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		wr_pend && wr_addr != step_sel_offset |=> $stable(step_sel))
		else $error("unmapped write landed");
	write_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		!wr_pend |=> $stable(step_sel))
		else $error("register moved without a write");
	bus_response_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		ahb_out.hreadyout && !ahb_out.hresp)
		else $error("bus response not okay");
	deselect_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		!ahb_in.sel |=> !wr_pend && !rd_hit)
		else $error("transfer taken while deselected");

	// sequencer side: only real steps give a valid pick
	step_none_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.step == 3'h7 |=> !step_sel_out.valid && step_sel_out.input_sel == 2'b00)
		else $error("no-step code gave a pick");
	step_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		!step_in.valid |=> !step_sel_out.valid)
		else $error("pick valid without a step");
	step_valid_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step != 3'h7 |=> step_sel_out.valid)
		else $error("real step gave no pick");

	// scenarios worth seeing at least once
	write_seen_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b)
		wr_pend && wr_addr == step_sel_offset);
	read_seen_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b) rd_hit);
	step7_nonzero_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h6 && step_sel[25:24] != 2'b00);
	unmapped_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b)
		addr_phase && !addr_ok);
	step1_nonzero_c: cover property (@(posedge clk_sys_in) disable iff (!rst_b)
		step_in.valid && step_in.step == 3'h0 && step1_input_sel != 2'b00);
endmodule // sample_step_input_select

/* File: rtl/step_sel_pkg.sv */
/*
 constants and carrier types for the sequence step input selector.
 assumes a 32-bit ahb-lite register bus and a sequencer giving a 3-bit step number.
*/
package step_sel_pkg;
	localparam int          step_count       = 7;
	localparam int          sel_width        = 2;
	localparam int          field_pitch      = 4;
	localparam logic [11:0] step_sel_offset  = 12'h000;
	localparam logic [11:0] step_sel_extra   = 12'h004;
	localparam logic [31:0] step_sel_reset   = 32'h0000_0000;
	localparam logic [31:0] step_sel_rw_mask = 32'h0333_3333;
	localparam logic [1:0]  htrans_nonseq    = 2'h2;
	localparam logic [1:0]  htrans_seq       = 2'h3;
	localparam logic [2:0]  hsize_word       = 3'h2;

	typedef struct packed {
		logic        sel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] step;
	} step_req_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] input_sel;
	} step_sel_t;
endpackage

/* File: testbench/sample_step_input_select_test.sv */
/*
 self-checking bench for the sequence step input selector.
 assumes zero wait states and a one-cycle registered step lookup.
*/
`timescale 1ns/1ns
module sample_step_input_select_test;
	import step_sel_pkg::*;
	logic        clk_sys_in;
	logic        rst_b_in;
	ahb_req_t    ahb_in;
	ahb_rsp_t    ahb_out;
	step_req_t   step_in;
	step_sel_t   step_sel_out;
	logic [31:0] rd;
	int          err_total = 0;
	int          n_tests = 0;

	sample_step_input_select u_sample_step_input_select (
		.clk_sys_in   (clk_sys_in),
		.rst_b_in     (rst_b_in),
		.ahb_in       (ahb_in),
		.ahb_out      (ahb_out),
		.step_in      (step_in),
		.step_sel_out (step_sel_out)
	);

	// single slave: its ready is the bus ready
	always @* ahb_in.hready = ahb_out.hreadyout;

	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
		ahb_in.sel <= 1'b1;
		ahb_in.haddr <= {20'h0_0000, a};
		ahb_in.htrans <= htrans_nonseq;
		ahb_in.hwrite <= w;
		ahb_in.hsize <= hsize_word;
		do @(posedge clk_sys_in); while (ahb_out.hreadyout !== 1'b1);
		ahb_in.sel <= 1'b0;
		ahb_in.htrans <= 2'h0;
		ahb_in.hwdata <= wd;
		do @(posedge clk_sys_in); while (ahb_out.hreadyout !== 1'b1);
		rd = ahb_out.hrdata;
	endtask

	task automatic run_step(input logic [2:0] s, input logic v, input logic [1:0] e);
		// two cycles of the same step, so the steady-register check also runs
		step_in <= '{valid: 1'b1, step: s};
		@(posedge clk_sys_in);
		#1;
		chk({31'h0, step_sel_out.valid}, {31'h0, v});
		chk({30'h0, step_sel_out.input_sel}, {30'h0, e});
		@(posedge clk_sys_in);
		step_in.valid <= 1'b0;
		#1;
		chk({31'h0, step_sel_out.valid}, {31'h0, v});
		chk({30'h0, step_sel_out.input_sel}, {30'h0, e});
		@(posedge clk_sys_in);
	endtask

	task automatic t_reset();
		bus(step_sel_offset, 1'b0, 32'h0);
		chk(rd, step_sel_reset);
	endtask

	// reserved bits must drop, unmapped word reads zero
	task automatic t_access();
		bus(step_sel_offset, 1'b1, 32'hffff_ffff);
		bus(step_sel_extra, 1'b1, 32'hffff_ffff);
		bus(step_sel_extra, 1'b0, 32'h0);
		chk(rd, 32'h0000_0000);
		bus(step_sel_offset, 1'b0, 32'h0);
		chk(rd, step_sel_rw_mask);
		// software side: change one field, write the rest back as read
		bus(step_sel_offset, 1'b1, (rd & ~32'h0000_0030) | 32'h0000_0010);
		bus(step_sel_offset, 1'b0, 32'h0);
		chk(rd, 32'h0333_3313);
	endtask

	// other fields held at 3 so a wrong field pick shows
	task automatic t_steps();
		for (int i = 0; i < step_count; i++) begin
			for (int v = 1; v < 3; v++) begin
				bus(step_sel_offset, 1'b1, (step_sel_rw_mask & ~(32'h3 << 4 * i)) | (v << 4 * i));
				run_step(i[2:0], 1'b1, v[1:0]);
			end
		end
		run_step(3'h7, 1'b0, 2'h0);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		rst_b_in = 1'b0;
		ahb_in.sel = 1'b0;
		ahb_in.haddr = 32'h0;
		ahb_in.htrans = 2'h0;
		ahb_in.hwrite = 1'b0;
		ahb_in.hsize = hsize_word;
		ahb_in.hwdata = 32'h0;
		step_in = '{valid: 1'b0, step: 3'h7};
		repeat (6) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		t_reset();
		t_access();
		t_steps();
		end_of_test();
	end

	initial begin
		#20000;
		err_total++;
		end_of_test();
	end
endmodule // sample_step_input_select_test
